//--- hdl/boot_pkg.sv
/*
 * Shared constants and types of the boot loader pair: strap codes, DMA
 * parameter reset values, boot vectors, register offsets and link timing.
 * Assumes one 50 MHz clock for both ends and a link clock period of 160 ns.
 */
package boot_pkg;
    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_HOST = 2'b01,
        MODE_LINK = 2'b10
    } boot_mode_t;

    // Strap order is {external, link, boot memory select}.
    localparam logic [2:0] STRAP_HOST = 3'h1;
    localparam logic [2:0] STRAP_LINK = 3'h3;

    localparam logic [31:0] EXT_DMA_CTRL_INIT = 32'h0000_0161;
    localparam int DEN_BIT = 0;
    localparam logic [18:0] BOOT_INDEX_INIT = 19'h4_0000;
    localparam logic [8:0] BOOT_COUNT_INIT = 9'h100;
    localparam logic [8:0] COUNT_LAST = 9'h001;
    localparam logic [18:0] IDLE_PC = 19'h4_0004;
    localparam logic [18:0] EXT_VECTOR = 19'h4_0050;
    localparam logic [18:0] LINK_VECTOR = 19'h4_0048;

    localparam logic [2:0] BYTES_PER_WORD = 3'h6;
    localparam logic [2:0] STEP_NARROW = 3'h1;
    localparam logic [2:0] STEP_WIDE = 3'h2;
    localparam logic [3:0] LAST_NIBBLE = 4'hB;
    localparam logic [15:0] SYSCFG_WIDE = 16'h0001;
    localparam int SYSCFG_WIDTH_BIT = 0;
    localparam logic HOST_SEL_BUFFER = 1'b0;
    localparam logic HOST_SEL_SYSCFG = 1'b1;

    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_INDEX = 8'h10;
    localparam logic [7:0] REG_DMA_CTRL = 8'h14;
    localparam int ST_EXT_DONE = 0;
    localparam int ST_LINK_DONE = 1;

    localparam int CLK_NS = 20;
    localparam int LINK_CLK_NS = 160;
    localparam logic [2:0] LINK_HALF = 3'(LINK_CLK_NS / CLK_NS / 2);
    localparam logic [2:0] LINK_LAST_PHASE = 3'(LINK_CLK_NS / CLK_NS - 1);
endpackage

//--- hdl/boot_link_if.sv
/*
 * Wires between the boot source and the booting device: boot straps, the
 * parallel host port and the nibble link. Both ends run on one clock,
 * except the straps and link pins, which the device treats as asynchronous.
 */
interface boot_link_if;
    logic external_boot_select;
    logic link_boot_select;
    logic boot_memory_select;
    logic host_bus_request;
    logic device_select;
    logic host_bus_grant;
    logic host_ready;
    logic host_write;
    logic host_addr_sel;
    logic [15:0] host_data;
    logic link_clk;
    logic [3:0] link_data;

    modport device (
        input external_boot_select, link_boot_select, boot_memory_select,
        input host_bus_request, device_select, host_write, host_addr_sel,
        input host_data, link_clk, link_data,
        output host_bus_grant, host_ready
    );
    modport host (
        output external_boot_select, link_boot_select, boot_memory_select,
        output host_bus_request, device_select, host_write, host_addr_sel,
        output host_data, link_clk, link_data,
        input host_bus_grant, host_ready
    );
endinterface

//--- hdl/link_nibble_rx.sv
/*
 * Link receiver of the booting device: gathers twelve nibbles, the first
 * one the most significant, into a 48-bit word.
 * Assumes the link data settle half a link period before each falling edge.
 */
module link_nibble_rx (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    // Link pins.
    input wire logic link_clk,
    input wire logic [3:0] link_data,
    // Assembled word.
    output logic word_valid,
    output logic [47:0] word
);
    import boot_pkg::*;

    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic [3:0] data_meta;
    logic [3:0] data_sync;
    logic [47:0] shift;
    logic [3:0] nibble_count;

    // Clock and data share the same delay, so a detected fall sees the data
    // that stood at the pin's falling edge.
    always_ff @(posedge clk) begin
        clk_meta <= link_clk;
        clk_sync <= clk_meta;
        data_meta <= link_data;
        data_sync <= data_meta;
    end

    wire fall = clk_prev && !clk_sync;
    wire [47:0] next_shift = {shift[43:0], data_sync};

    always_ff @(posedge clk) begin
        if (reset) begin
            clk_prev <= 1'b0;
            shift <= '0;
            nibble_count <= '0;
            word_valid <= 1'b0;
            word <= '0;
        end else begin
            clk_prev <= clk_sync;
            word_valid <= 1'b0;
            if (enable && fall) begin
                shift <= next_shift;
                if (nibble_count == LAST_NIBBLE) begin
                    nibble_count <= '0;
                    word_valid <= 1'b1;
                    word <= next_shift;
                end else begin
                    nibble_count <= nibble_count + 4'h1;
                end
            end
        end
    end
endmodule

//--- hdl/boot_device_end.sv
/*
 * Booting device end: reads the boot straps after reset, takes boot words
 * from a host over the parallel port or from the nibble link, writes 256
 * instructions to internal memory, then raises an interrupt and runs.
 * Assumes the host end shares clk; straps and link pins are asynchronous.
 */
// Chosen here: the placing of the registers and the plain strobed port.
// Notes on behaviour
// - Straps 0,0,1 select host boot
// - Host boot waits as slave for download
// - Pack 8 or 16 bit data into 48
// - Load 256 words at 0x40000 to 0x400FF
// - Idle with PC 0x40004 while loading
// - Host channel index 0x40000, count 0x100
// - Host channel control loads 0x161
// - Host arbitrates with request and select first
// - Host may set width in system config
// - Host writes boot words to buffer zero
// - Count to zero stops, interrupts, vectors 0x40050
// - Straps 0,1,1 select link boot
// - Link boot takes nibbles via link channel
// - Link clock external, nibble taken on falling
// - Source sends most significant nibble first
// - Link channel index 0x40000, count 0x100
// - Link buffer forced to 48-bit words
// - Multi-device systems always boot over buffer zero
module boot_device_end (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Boot pins.
    boot_link_if.device bus,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Internal memory write port.
    output logic mem_write,
    output logic [18:0] mem_addr,
    output logic [47:0] mem_data,
    // Core state.
    output logic core_idle,
    output logic [18:0] program_counter,
    output logic [1:0] boot_mode,
    output logic irq
);
    import boot_pkg::*;

    typedef enum logic [2:0] {
        DEV_CAPTURE = 3'b000,
        DEV_HOST = 3'b001,
        DEV_LINK = 3'b010,
        DEV_RUN = 3'b011,
        DEV_NO_LOAD = 3'b100
    } dev_state_t;

    dev_state_t state;
    dev_state_t next_state;
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic [18:0] index;
    logic [8:0] count;
    logic [31:0] dma_ctrl;
    logic width_wide;
    logic [47:0] pack;
    logic [2:0] pos;
    logic [1:0] status;
    logic [1:0] mask;
    logic link_word_valid;
    logic [47:0] link_word;

    // The strap pins are sampled only after both synchroniser stages.
    always_ff @(posedge clk) begin
        strap_meta <= {bus.external_boot_select, bus.link_boot_select,
                       bus.boot_memory_select};
        strap_sync <= strap_meta;
    end

    wire strap_host = strap_sync == STRAP_HOST;
    wire strap_link = strap_sync == STRAP_LINK;
    wire in_host = state == DEV_HOST;
    wire in_link = state == DEV_LINK;
    wire dma_on = dma_ctrl[DEN_BIT];

    // Host port: the device answers as a slave only while loading.
    wire host_access = in_host && dma_on && bus.host_bus_request
                       && bus.device_select;
    assign bus.host_bus_grant = host_access;
    assign bus.host_ready = host_access;
    wire host_wr = host_access && bus.host_write;
    wire buf_wr = host_wr && bus.host_addr_sel == HOST_SEL_BUFFER;
    wire cfg_wr = host_wr && bus.host_addr_sel == HOST_SEL_SYSCFG;

    // Pieces arrive least significant first and shift in from the top.
    wire [2:0] step = width_wide ? STEP_WIDE : STEP_NARROW;
    wire [2:0] pos_sum = pos + step;
    wire [47:0] pack_shift = width_wide ?
        {bus.host_data, pack[47:16]} :
        {bus.host_data[7:0], pack[47:8]};
    wire host_word = buf_wr && pos_sum == BYTES_PER_WORD;

    link_nibble_rx link_rx (
        .clk(clk),
        .reset(reset),
        .enable(in_link),
        .link_clk(bus.link_clk),
        .link_data(bus.link_data),
        .word_valid(link_word_valid),
        .word(link_word)
    );

    wire word_valid = host_word || (in_link && link_word_valid);
    wire [47:0] word_in = in_host ? pack_shift : link_word;
    wire last_word = word_valid && count == COUNT_LAST;
    wire set_ext = last_word && in_host;
    wire set_link = last_word && in_link;

    always_comb begin
        next_state = state;
        unique case (state)
            DEV_CAPTURE: begin
                if (strap_host) begin
                    next_state = DEV_HOST;
                end else if (strap_link) begin
                    next_state = DEV_LINK;
                end else begin
                    next_state = DEV_NO_LOAD;
                end
            end
            DEV_HOST, DEV_LINK: begin
                if (last_word) begin
                    next_state = DEV_RUN;
                end
            end
            DEV_RUN, DEV_NO_LOAD: begin
                next_state = state;
            end
            default: begin
                next_state = DEV_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= DEV_CAPTURE;
            boot_mode <= MODE_NONE;
            program_counter <= IDLE_PC;
        end else begin
            state <= next_state;
            if (state == DEV_CAPTURE) begin
                boot_mode <= strap_host ? MODE_HOST :
                             strap_link ? MODE_LINK : MODE_NONE;
            end
            if (set_ext) begin
                program_counter <= EXT_VECTOR;
            end else if (set_link) begin
                program_counter <= LINK_VECTOR;
            end
        end
    end

    // The core stays parked until the last boot word has been written.
    assign core_idle = state != DEV_RUN;

    // Boot channel parameters; both channels share one index and count.
    always_ff @(posedge clk) begin
        if (reset) begin
            index <= BOOT_INDEX_INIT;
            count <= BOOT_COUNT_INIT;
        end else if (word_valid) begin
            index <= index + 19'h1;
            count <= count - 9'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dma_ctrl <= '0;
        end else if (state == DEV_CAPTURE) begin
            dma_ctrl <= strap_host ? EXT_DMA_CTRL_INIT : '0;
        end else if (reg_write && reg_addr == REG_DMA_CTRL) begin
            dma_ctrl <= reg_wdata;
        end else if (set_ext) begin
            dma_ctrl[DEN_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            width_wide <= 1'b0;
            pack <= '0;
            pos <= '0;
        end else begin
            if (cfg_wr) begin
                width_wide <= bus.host_data[SYSCFG_WIDTH_BIT];
            end
            if (buf_wr) begin
                pack <= pack_shift;
                pos <= host_word ? 3'h0 : pos_sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mem_write <= 1'b0;
            mem_addr <= '0;
            mem_data <= '0;
        end else begin
            mem_write <= word_valid;
            if (word_valid) begin
                mem_addr <= index;
                mem_data <= word_in;
            end
        end
    end

    // Interrupt status: a completion in the clearing cycle survives.
    wire status_wr = reg_write && reg_addr == REG_STATUS;
    wire [1:0] clear_bits = status_wr ? reg_wdata[1:0] : 2'h0;
    wire [1:0] set_bits = {set_link, set_ext};
    wire [1:0] next_status = (status & ~clear_bits) | set_bits;

    always_ff @(posedge clk) begin
        if (reset) begin
            status <= '0;
            mask <= '0;
        end else begin
            status <= next_status;
            if (reg_write && reg_addr == REG_MASK) begin
                mask <= reg_wdata[1:0];
            end
        end
    end

    assign irq = |(status & mask);

    wire [31:0] read_value =
        reg_addr == REG_STATUS ? {30'h0, status} :
        reg_addr == REG_MASK ? {30'h0, mask} :
        reg_addr == REG_MODE ? {27'h0, state, boot_mode} :
        reg_addr == REG_COUNT ? {23'h0, count} :
        reg_addr == REG_INDEX ? {13'h0, index} :
        reg_addr == REG_DMA_CTRL ? dma_ctrl : 32'h0;

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? read_value : 32'h0;
        end
    end
endmodule

//--- hdl/boot_host_end.sv
/*
 * Boot source end: sets the boot straps, then either arbitrates for the
 * device's parallel port and writes each word in 8- or 16-bit pieces, or
 * drives the link clock from a divider and sends twelve nibbles a word.
 * Assumes the device shares clk and that its DMA stays enabled.
 */
module boot_host_end (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Boot pins.
    boot_link_if.host bus,
    // User side.
    input wire logic use_link_boot,
    input wire logic use_wide_bus,
    input wire logic start,
    input wire logic word_valid,
    input wire logic [47:0] word,
    output logic word_ready,
    output logic busy
);
    import boot_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_ARB = 3'b001,
        H_CFG = 3'b010,
        H_WAIT = 3'b011,
        H_PIECES = 3'b100,
        H_LINK = 3'b101
    } host_state_t;

    host_state_t state;
    logic [47:0] shreg;
    logic [2:0] left;
    logic [2:0] phase;
    logic [3:0] nibble;

    assign word_ready = state == H_WAIT;
    // Busy covers arbitration and a word in flight, not waiting for words.
    assign busy = state != H_IDLE && state != H_WAIT;
    wire [2:0] step = use_wide_bus ? STEP_WIDE : STEP_NARROW;

    // The straps follow the chosen mode during reset too, so that they have
    // passed the device's synchroniser before the device samples them.
    always_ff @(posedge clk) begin
        bus.external_boot_select <= 1'b0;
        bus.link_boot_select <= use_link_boot;
        bus.boot_memory_select <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= H_IDLE;
            bus.host_bus_request <= 1'b0;
            bus.device_select <= 1'b0;
            bus.host_write <= 1'b0;
            bus.host_addr_sel <= HOST_SEL_BUFFER;
            bus.host_data <= '0;
            bus.link_clk <= 1'b0;
            bus.link_data <= '0;
            shreg <= '0;
            left <= '0;
            phase <= '0;
            nibble <= '0;
        end else begin
            bus.host_write <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    if (start && use_link_boot) begin
                        state <= H_WAIT;
                    end else if (start) begin
                        bus.host_bus_request <= 1'b1;
                        bus.device_select <= 1'b1;
                        state <= H_ARB;
                    end
                end
                H_ARB: begin
                    if (bus.host_bus_grant && bus.host_ready) begin
                        state <= use_wide_bus ? H_CFG : H_WAIT;
                    end
                end
                H_CFG: begin
                    bus.host_write <= 1'b1;
                    bus.host_addr_sel <= HOST_SEL_SYSCFG;
                    bus.host_data <= SYSCFG_WIDE;
                    state <= H_WAIT;
                end
                H_WAIT: begin
                    if (word_valid) begin
                        shreg <= word;
                        left <= BYTES_PER_WORD;
                        phase <= '0;
                        nibble <= '0;
                        state <= use_link_boot ? H_LINK : H_PIECES;
                    end
                end
                H_PIECES: begin
                    bus.host_write <= 1'b1;
                    bus.host_addr_sel <= HOST_SEL_BUFFER;
                    bus.host_data <= use_wide_bus ? shreg[15:0] :
                                     {8'h0, shreg[7:0]};
                    shreg <= use_wide_bus ? {16'h0, shreg[47:16]} :
                                            {8'h0, shreg[47:8]};
                    left <= left - step;
                    if (left == step) begin
                        state <= H_WAIT;
                    end
                end
                H_LINK: begin
                    phase <= phase + 3'h1;
                    if (phase == 3'h0) begin
                        bus.link_clk <= 1'b1;
                        bus.link_data <= shreg[47:44];
                        shreg <= {shreg[43:0], 4'h0};
                    end else if (phase == LINK_HALF) begin
                        bus.link_clk <= 1'b0;
                    end else if (phase == LINK_LAST_PHASE) begin
                        phase <= '0;
                        nibble <= nibble + 4'h1;
                        if (nibble == LAST_NIBBLE) begin
                            state <= H_WAIT;
                        end
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verification/boot_link_chk.sv
/*
 * Checker for the boot pins between the boot source and the device.
 * Assumes both ends share clk and a synchronous active-high reset.
 */
module boot_link_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Boot pins.
    input wire logic external_boot_select,
    input wire logic link_boot_select,
    input wire logic boot_memory_select,
    input wire logic host_bus_request,
    input wire logic device_select,
    input wire logic host_bus_grant,
    input wire logic host_ready,
    input wire logic host_write,
    input wire logic link_clk,
    input wire logic [3:0] link_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_strap_levels: assert property (
        boot_memory_select && !external_boot_select)
        else $error("boot straps wrong");
    a_grant_cause: assert property (
        host_bus_grant |-> host_bus_request && device_select)
        else $error("grant without request and select");
    a_ready_grant: assert property (
        host_ready == host_bus_grant)
        else $error("ready differs from grant");
    a_grant_follows: assert property (
        $rose(host_bus_request) |-> ##[0:4] host_bus_grant && host_ready)
        else $error("host request not granted in time");
    a_write_granted: assert property (
        host_write |-> host_bus_grant)
        else $error("host write without grant");
    a_link_no_grant: assert property (
        link_boot_select |-> !host_bus_grant)
        else $error("host port granted in link boot");
    a_clk_high: assert property (
        $rose(link_clk) |=> link_clk [*3] ##1 !link_clk)
        else $error("link clock high phase wrong");
    a_clk_low: assert property (
        $fell(link_clk) |=> !link_clk [*3])
        else $error("link clock low phase short");
    a_data_at_rise: assert property (
        $changed(link_data) |-> $rose(link_clk))
        else $error("link data changed away from rise");
    a_link_quiet: assert property (
        !link_boot_select |-> !link_clk)
        else $error("link clock runs outside link boot");
endmodule

//--- verification/tb_top.sv
/*
 * Bench joining the boot source and the device: host boot 8 and 16 bit,
 * then link boot, each loading 256 random words.
 * Assumes one 50 MHz clock and synchronous active-high reset.
 */
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("wrong value %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import boot_pkg::*;

    logic clk, reset, use_link_boot, use_wide_bus, start, word_valid;
    logic [47:0] word, mem_data;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, re;
    logic reg_write, reg_read, rd_q, word_ready, busy;
    logic mem_write, core_idle, irq;
    logic [18:0] mem_addr, program_counter;
    logic [1:0] boot_mode;
    logic [66:0] me;
    logic [66:0] mem_q[$];
    logic [31:0] reg_q[$];
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'hb5d2;

    boot_link_if bus();
    boot_host_end u_boot_host_end (.clk(clk), .reset(reset), .bus(bus),
        .use_link_boot(use_link_boot), .use_wide_bus(use_wide_bus),
        .start(start), .word_valid(word_valid), .word(word),
        .word_ready(word_ready), .busy(busy));
    boot_device_end u_boot_device_end (.clk(clk), .reset(reset),
        .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_data(mem_data),
        .core_idle(core_idle), .program_counter(program_counter),
        .boot_mode(boot_mode), .irq(irq));
    boot_link_chk u_boot_link_chk (.clk(clk), .reset(reset),
        .external_boot_select(bus.external_boot_select),
        .link_boot_select(bus.link_boot_select),
        .boot_memory_select(bus.boot_memory_select),
        .host_bus_request(bus.host_bus_request),
        .device_select(bus.device_select),
        .host_bus_grant(bus.host_bus_grant), .host_ready(bus.host_ready),
        .host_write(bus.host_write), .link_clk(bus.link_clk),
        .link_data(bus.link_data));

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_q.push_back(e);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask

    // Holds the word offered until the edge where word_ready is seen.
    task send_word(input logic [47:0] w, input int k);
        word <= w;
        word_valid <= 1'b1;
        mem_q.push_back({BOOT_INDEX_INIT + 19'(k), w});
        @(posedge clk);
        while (word_ready !== 1'b1) @(posedge clk);
    endtask

    task run_boot(input string nm, input logic lnk, input logic wide);
        int k;
        reset <= 1'b1;
        use_link_boot <= lnk;
        use_wide_bus <= wide;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        reg_rd(REG_DMA_CTRL, lnk ? 32'h0 : EXT_DMA_CTRL_INIT);
        reg_rd(REG_INDEX, 32'(BOOT_INDEX_INIT));
        reg_rd(REG_COUNT, 32'(BOOT_COUNT_INIT));
        `CHK("program_counter", IDLE_PC, program_counter)
        `CHK("boot_mode", lnk ? MODE_LINK : MODE_HOST, boot_mode)
        `CHK("core_idle", 1'b1, core_idle)
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 256; k++) begin
            send_word(48'({$random(seed), $random(seed)}), k);
        end
        word_valid <= 1'b0;
        k = 0;
        while (core_idle !== 1'b0 && k < 600) begin
            @(posedge clk);
            k++;
        end
        repeat (2) @(posedge clk);
        `CHK("vector", lnk ? LINK_VECTOR : EXT_VECTOR, program_counter)
        `CHK("pending", 0, mem_q.size())
        `CHK("busy", 1'b0, busy)
        `CHK("irq masked", 1'b0, irq)
        reg_rd(REG_STATUS, lnk ? 32'h2 : 32'h1);
        reg_rd(REG_COUNT, 32'h0);
        reg_rd(REG_DMA_CTRL, lnk ? 32'h0 : 32'h160);
        reg_wr(REG_MASK, 32'h3);
        @(posedge clk);
        `CHK("irq", 1'b1, irq)
        reg_wr(REG_STATUS, 32'h3);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        reg_rd(REG_STATUS, 32'h0);
        reg_rd(8'h20, 32'h0);
        repeat (2) @(posedge clk);
        $display("test %s done", nm);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compares each register read and memory write with the oldest note.
    always @(posedge clk) begin
        rd_q <= reg_read;
        if (rd_q === 1'b1) begin
            re = reg_q.size() ? reg_q.pop_front() : 'X;
            `CHK("reg_rdata", re, reg_rdata)
        end
        if (mem_write === 1'b1) begin
            me = mem_q.size() ? mem_q.pop_front() : 'X;
            `CHK("mem_word", me, {mem_addr, mem_data})
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("timeout after %0d cycles", cycles);
            complete_run();
        end
    end

    initial begin
        reset = 1'b1;
        use_link_boot = 1'b0;
        use_wide_bus = 1'b0;
        start = 1'b0;
        word_valid = 1'b0;
        word = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        run_boot("host_narrow", 1'b0, 1'b0);
        run_boot("host_wide", 1'b0, 1'b1);
        run_boot("link", 1'b1, 1'b0);
        complete_run();
    end
endmodule
